/* rtl/dds_regs_pkg.sv */
// Package holding the serial map, field positions, reset values and port states of the synthesizer register bank.
// Assumes the serial port logic and the staging registers run on one synchronisation clock.
package dds_regs_pkg;

   // ****************************************
   // Serial address map
   // ****************************************
   localparam logic [4:0] ADDR_CTRL       = 5'h00;
   localparam logic [4:0] ADDR_UNUSED     = 5'h05;
   localparam logic [4:0] ADDR_PROF_FIRST = 5'h09;
   localparam logic [4:0] ADDR_PROF7      = 5'h10;
   localparam logic [4:0] ADDR_LAST       = 5'h10;

   // Instruction byte layout: a set top bit asks for a read.
   localparam int INSTR_READ_BIT = 7;
   localparam int INSTR_ADDR_MSB = 4;

   // Bytes carried per slot.
   localparam logic [2:0] CTRL_BYTES   = 3'h4;
   localparam logic [2:0] PROF_BYTES   = 3'h6;
   localparam logic [2:0] UNUSED_BYTES = 3'h1;
   localparam logic [2:0] OTHER_BYTES  = 3'h4;

   // ****************************************
   // First control register fields
   // ****************************************
   localparam int CTRL_MODULUS_BIT   = 28;
   localparam int CTRL_INT_PROF_BIT  = 27;
   localparam int CTRL_NO_MATCH_BIT  = 26;
   localparam int CTRL_LSB_FIRST_BIT = 23;
   localparam int CTRL_PROF_SEL_MSB  = 22;
   localparam int CTRL_PROF_SEL_LSB  = 20;
   localparam int CTRL_LSB_FIRST_IDX = 2;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   localparam logic [31:0] CTRL_IMMEDIATE = 32'h0080_0000;

   // ****************************************
   // Profile register fields
   // ****************************************
   localparam int PROF_FTW_MSB = 31;
   localparam int PROF_POW_LSB = 32;
   localparam int PROF_POW_MSB = 45;
   localparam logic [47:0] PROF7_RESET     = 48'h0000_0000_0000;
   localparam logic [47:0] PROF7_IMMEDIATE = 48'h0000_0000_0000;

   // ****************************************
   // Serial port states
   // ****************************************
   typedef enum logic [1:0] {
      ST_INSTR = 2'b00,
      ST_DATA  = 2'b01,
      ST_SKIP  = 2'b10
   } port_state_e;

   function automatic logic [2:0] slot_bytes(input logic [4:0] addr);
      logic [2:0] n;
      n = OTHER_BYTES;
      if (addr == ADDR_CTRL) begin
         n = CTRL_BYTES;
      end else if (addr == ADDR_UNUSED) begin
         n = UNUSED_BYTES;
      end else if (addr >= ADDR_PROF_FIRST) begin
         n = PROF_BYTES;
      end
      return n;
   endfunction

endpackage

/* rtl/serial_byte_shifter.sv */
// Byte shifter for the serial programming port, receive and transmit.
// Assumes sample and shift strobes are one-cycle pulses derived from a synchronised serial clock.
`timescale 1ns/10ps
`default_nettype none
module serial_byte_shifter (
   // System.
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // Strobes from the port.
   input  wire logic       frame_in,
   input  wire logic       sample_in,
   input  wire logic       shift_in,
   input  wire logic       bit_in,
   input  wire logic       lsb_first_in,
   // Transmit load.
   input  wire logic       load_in,
   input  wire logic [7:0] load_byte_in,
   // Results.
   output logic            byte_done_out,
   output logic [7:0]      byte_out,
   output logic            tx_bit_out
);

   logic [2:0] cnt_r;
   logic [7:0] rx_r;
   logic [7:0] rx_nxt;
   logic [7:0] tx_r;
   logic [7:0] tx_nxt;

   assign rx_nxt = lsb_first_in ? {bit_in, rx_r[7:1]} : {rx_r[6:0], bit_in};
   assign tx_nxt = lsb_first_in ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};

   always_ff @(posedge clk_in) begin
      if (rst_in || !frame_in) begin
         cnt_r <= 3'h0;
         rx_r <= 8'h00;
         byte_done_out <= 1'b0;
         byte_out <= 8'h00;
      end else begin
         byte_done_out <= sample_in && (cnt_r == 3'h7);
         if (sample_in) begin
            cnt_r <= 3'(cnt_r + 3'h1);
            rx_r <= rx_nxt;
            byte_out <= rx_nxt;
         end
      end
   end

   // A falling edge at a byte boundary is ignored so the freshly loaded first bit survives.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_r <= 8'h00;
         tx_bit_out <= 1'b0;
      end else if (load_in) begin
         tx_r <= load_byte_in;
         tx_bit_out <= lsb_first_in ? load_byte_in[0] : load_byte_in[7];
      end else if (shift_in && frame_in && cnt_r != 3'h0) begin
         tx_r <= tx_nxt;
         tx_bit_out <= lsb_first_in ? tx_r[1] : tx_r[6];
      end
   end

endmodule
`default_nettype wire

/* rtl/register_staging.sv */
// Holding buffer and active copy of one register, byte addressed.
// Assumes the commit strobe is a one-cycle pulse on the same clock as the byte writes.
`timescale 1ns/10ps
`default_nettype none
module register_staging #(
   parameter int                 BYTES          = 4,
   parameter logic [8*BYTES-1:0] RESET_VALUE    = '0,
   parameter logic [8*BYTES-1:0] IMMEDIATE_MASK = '0
) (
   // System.
   input  wire logic               clk_in,
   input  wire logic               rst_in,
   // Byte write and commit.
   input  wire logic               wr_en_in,
   input  wire logic [2:0]         wr_idx_in,
   input  wire logic [7:0]         wr_data_in,
   input  wire logic               commit_in,
   // Read back of the holding buffer.
   input  wire logic [2:0]         rd_idx_in,
   output logic [7:0]              rd_data_out,
   // Contents.
   output logic [8*BYTES-1:0]      hold_out,
   output logic [8*BYTES-1:0]      active_out
);

   logic [7:0] rd_bytes [0:7];

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_byte
         if (i < BYTES) begin : g_real
            logic       sel;
            logic [7:0] mask;
            logic [7:0] base;
            assign sel  = wr_en_in && (wr_idx_in == 3'(i));
            assign mask = IMMEDIATE_MASK[8*i +: 8];
            assign base = commit_in ? hold_out[8*i +: 8] : active_out[8*i +: 8];
            assign rd_bytes[i] = hold_out[8*i +: 8];

            always_ff @(posedge clk_in) begin
               if (rst_in) begin
                  hold_out[8*i +: 8] <= RESET_VALUE[8*i +: 8];
               end else if (sel) begin
                  hold_out[8*i +: 8] <= wr_data_in;
               end
            end

            // Immediate bits land when their byte completes; the rest wait for the commit.
            always_ff @(posedge clk_in) begin
               if (rst_in) begin
                  active_out[8*i +: 8] <= RESET_VALUE[8*i +: 8];
               end else if (sel) begin
                  active_out[8*i +: 8] <= (base & ~mask) | (wr_data_in & mask);
               end else begin
                  active_out[8*i +: 8] <= base;
               end
            end
         end else begin : g_none
            assign rd_bytes[i] = 8'h00;
         end
      end
   endgenerate

   assign rd_data_out = rd_bytes[rd_idx_in];

endmodule
`default_nettype wire

/* rtl/dds_control_register_bank.sv */
// Register bank of a direct digital synthesizer behind its serial programming port.
// Assumes pins arrive asynchronously and the serial clock runs well below a quarter of clk_in.
//
// Notes on behaviour
// RULE_01: Immediate bits act once their byte completes.
// RULE_02: Serial addresses 0x00 to 0x10 are decoded.
// RULE_03: Slot 0x05 is empty, no register behind.
// RULE_04: Each transfer carries the register's own byte count.
// RULE_05: Bit zero is the least significant bit.
// RULE_06: Written bits wait in buffers until commit strobe.
// RULE_07: First control register at 0x00, four bytes.
// RULE_08: Host keeps control bits 31:29 at defaults.
// RULE_09: Bit 28 picks modulus or sweep, sweep-gated.
// RULE_10: Bit 27 picks profile pins or bits 22:20.
// RULE_11: Bit 26 clear matches the pipeline latencies.
// RULE_12: Host keeps control bits 25:24 at defaults.
// RULE_13: Bit 23 sets serial bit order both ends.
// RULE_14: Profile seven: tuning word, phase word, zero reset.
// RULE_15: Unused slot ignores writes and reads zero.
`timescale 1ns/10ps
`default_nettype none
module dds_control_register_bank (
   // System.
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Serial port pins.
   input  wire logic        sclk_in,
   input  wire logic        cs_n_in,
   input  wire logic        sdio_in,
   output logic             sdio_out,
   output logic             sdio_oe_out,
   // Commit strobe and profile pins.
   input  wire logic        io_update_in,
   input  wire logic [2:0]  profile_pins_in,
   // Linear sweep enable from the lower control logic.
   input  wire logic        sweep_enable_in,
   // Active controls.
   output logic [31:0]      control_word_out,
   output logic             aux_modulus_out,
   output logic             aux_sweep_out,
   output logic [2:0]       profile_sel_out,
   output logic             latency_match_out,
   output logic             lsb_first_out,
   output logic [31:0]      ftw_out,
   output logic [13:0]      pow_out
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic       sclk_s1_r;
   logic       sclk_s2_r;
   logic       sclk_d_r;
   logic       cs_n_s1_r;
   logic       cs_n_s2_r;
   logic       sdio_s1_r;
   logic       sdio_s2_r;
   logic       upd_s1_r;
   logic       upd_s2_r;
   logic       upd_d_r;
   logic [2:0] prof_s1_r;
   logic [2:0] prof_s2_r;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sclk_s1_r <= 1'b0;
         sclk_s2_r <= 1'b0;
         sclk_d_r <= 1'b0;
         cs_n_s1_r <= 1'b1;
         cs_n_s2_r <= 1'b1;
         sdio_s1_r <= 1'b0;
         sdio_s2_r <= 1'b0;
         upd_s1_r <= 1'b0;
         upd_s2_r <= 1'b0;
         upd_d_r <= 1'b0;
         prof_s1_r <= 3'h0;
         prof_s2_r <= 3'h0;
      end else begin
         sclk_s1_r <= sclk_in;
         sclk_s2_r <= sclk_s1_r;
         sclk_d_r <= sclk_s2_r;
         cs_n_s1_r <= cs_n_in;
         cs_n_s2_r <= cs_n_s1_r;
         sdio_s1_r <= sdio_in;
         sdio_s2_r <= sdio_s1_r;
         upd_s1_r <= io_update_in;
         upd_s2_r <= upd_s1_r;
         upd_d_r <= upd_s2_r;
         prof_s1_r <= profile_pins_in;
         prof_s2_r <= prof_s1_r;
      end
   end

   logic frame;
   logic sclk_rise;
   logic sclk_fall;
   logic commit;

   assign frame     = !cs_n_s2_r;
   assign sclk_rise = sclk_s2_r && !sclk_d_r;
   assign sclk_fall = !sclk_s2_r && sclk_d_r;
   assign commit    = upd_s2_r && !upd_d_r; // [RULE_06]

   // ****************************************
   // Byte shifter
   // ****************************************
   logic        byte_done;
   logic [7:0]  rx_byte;
   logic        ld;
   logic [7:0]  ld_byte;
   logic [31:0] cfr_hold;
   logic [31:0] cfr_active;
   logic [47:0] prof_hold;
   logic [47:0] prof_active;

   serial_byte_shifter u_shifter (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .frame_in      (frame),
      .sample_in     (sclk_rise),
      .shift_in      (sclk_fall),
      .bit_in        (sdio_s2_r),
      .lsb_first_in  (cfr_active[dds_regs_pkg::CTRL_LSB_FIRST_BIT]), // [RULE_13]
      .load_in       (ld),
      .load_byte_in  (ld_byte),
      .byte_done_out (byte_done),
      .byte_out      (rx_byte),
      .tx_bit_out    (sdio_out)
   );

   // ****************************************
   // Transfer sequencing
   // ****************************************
   dds_regs_pkg::port_state_e state_r;
   logic [4:0]  addr_r;
   logic        read_r;
   logic [2:0]  cnt_r;
   logic [2:0]  len_r;
   logic        oe_r;
   logic        order_r;

   logic        lsb_first;
   logic [4:0]  instr_addr;
   logic        instr_read;
   logic        instr_ok;
   logic        in_instr;
   logic        in_data;
   logic        last_byte;
   logic [2:0]  wr_idx;
   logic        wr_any;
   logic        wr_cfr;
   logic        wr_prof;
   logic [4:0]  ld_addr;
   logic [2:0]  ld_cnt;
   logic [2:0]  ld_len;
   logic [2:0]  ld_idx;
   logic        ld_order;
   logic [7:0]  cfr_rd;
   logic [7:0]  prof_rd;

   assign lsb_first  = cfr_active[dds_regs_pkg::CTRL_LSB_FIRST_BIT];
   assign instr_addr = rx_byte[dds_regs_pkg::INSTR_ADDR_MSB:0];
   assign instr_read = rx_byte[dds_regs_pkg::INSTR_READ_BIT];
   assign instr_ok   = instr_addr <= dds_regs_pkg::ADDR_LAST; // [RULE_02]
   assign in_instr   = byte_done && state_r == dds_regs_pkg::ST_INSTR;
   assign in_data    = byte_done && state_r == dds_regs_pkg::ST_DATA;
   assign last_byte  = cnt_r == 3'(len_r - 3'h1); // [RULE_04]

   // Bytes travel most significant first unless the order bit is set; bit zero is the register LSB.
   // The byte order is held for the whole transfer, so an immediate order change only alters bit order.
   assign wr_idx  = order_r ? cnt_r : 3'(len_r - 3'h1 - cnt_r); // [RULE_05] [RULE_13]
   assign wr_any  = in_data && !read_r;
   assign wr_cfr  = wr_any && addr_r == dds_regs_pkg::ADDR_CTRL; // [RULE_07]
   assign wr_prof = wr_any && addr_r == dds_regs_pkg::ADDR_PROF7; // [RULE_14]

   // The next read byte is fetched right after the instruction or after each data byte but the last.
   assign ld      = (in_instr && instr_read && instr_ok) || (in_data && read_r && !last_byte);
   assign ld_addr = in_instr ? instr_addr : addr_r;
   assign ld_cnt  = in_instr ? 3'h0 : 3'(cnt_r + 3'h1);
   assign ld_len  = in_instr ? dds_regs_pkg::slot_bytes(instr_addr) : len_r;
   assign ld_order = in_instr ? lsb_first : order_r;
   assign ld_idx  = ld_order ? ld_cnt : 3'(ld_len - 3'h1 - ld_cnt);
   assign ld_byte = (ld_addr == dds_regs_pkg::ADDR_CTRL)  ? cfr_rd :
                    (ld_addr == dds_regs_pkg::ADDR_PROF7) ? prof_rd : 8'h00; // [RULE_03] [RULE_15]

   always_ff @(posedge clk_in) begin
      if (rst_in || !frame) begin
         state_r <= dds_regs_pkg::ST_INSTR;
         addr_r <= 5'h00;
         read_r <= 1'b0;
         cnt_r <= 3'h0;
         len_r <= 3'h1;
         order_r <= 1'b0;
      end else if (byte_done) begin
         unique case (state_r)
            dds_regs_pkg::ST_INSTR: begin
               addr_r <= instr_addr;
               read_r <= instr_read;
               cnt_r <= 3'h0;
               len_r <= dds_regs_pkg::slot_bytes(instr_addr); // [RULE_04]
               order_r <= lsb_first; // [RULE_13]
               state_r <= instr_ok ? dds_regs_pkg::ST_DATA : dds_regs_pkg::ST_SKIP; // [RULE_02]
            end
            dds_regs_pkg::ST_DATA: begin
               cnt_r <= 3'(cnt_r + 3'h1);
               if (last_byte) begin
                  state_r <= dds_regs_pkg::ST_INSTR;
               end
            end
            dds_regs_pkg::ST_SKIP: begin
               state_r <= dds_regs_pkg::ST_SKIP;
            end
            default: begin
               state_r <= dds_regs_pkg::ST_INSTR;
            end
         endcase
      end
   end

   // The data line is only driven while a read is in its data phase.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         oe_r <= 1'b0;
      end else begin
         oe_r <= frame && (ld || (state_r == dds_regs_pkg::ST_DATA && read_r && !(in_data && last_byte)));
      end
   end

   assign sdio_oe_out = oe_r;

   // ****************************************
   // Staged registers
   // ****************************************
   register_staging #(
      .BYTES          (4),
      .RESET_VALUE    (dds_regs_pkg::CTRL_RESET),
      .IMMEDIATE_MASK (dds_regs_pkg::CTRL_IMMEDIATE)
   ) u_ctrl (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .wr_en_in    (wr_cfr),
      .wr_idx_in   (wr_idx),
      .wr_data_in  (rx_byte),
      .commit_in   (commit),
      .rd_idx_in   (ld_idx),
      .rd_data_out (cfr_rd),
      .hold_out    (cfr_hold),
      .active_out  (cfr_active)
   ); // [RULE_01] [RULE_06]

   register_staging #(
      .BYTES          (6),
      .RESET_VALUE    (dds_regs_pkg::PROF7_RESET),
      .IMMEDIATE_MASK (dds_regs_pkg::PROF7_IMMEDIATE)
   ) u_prof7 (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .wr_en_in    (wr_prof),
      .wr_idx_in   (wr_idx),
      .wr_data_in  (rx_byte),
      .commit_in   (commit),
      .rd_idx_in   (ld_idx),
      .rd_data_out (prof_rd),
      .hold_out    (prof_hold),
      .active_out  (prof_active)
   ); // [RULE_06] [RULE_14]

   // ****************************************
   // Control outputs
   // ****************************************
   logic       aux_modulus;
   logic       aux_sweep;
   logic [2:0] prof_sel;

   // Routing of the auxiliary accumulator is meaningless with sweep off, so both go low then.
   assign aux_modulus = sweep_enable_in && cfr_active[dds_regs_pkg::CTRL_MODULUS_BIT]; // [RULE_09]
   assign aux_sweep   = sweep_enable_in && !cfr_active[dds_regs_pkg::CTRL_MODULUS_BIT]; // [RULE_09]
   assign prof_sel    = cfr_active[dds_regs_pkg::CTRL_INT_PROF_BIT] ?
                        cfr_active[dds_regs_pkg::CTRL_PROF_SEL_MSB:dds_regs_pkg::CTRL_PROF_SEL_LSB] :
                        prof_s2_r; // [RULE_10]

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         control_word_out <= dds_regs_pkg::CTRL_RESET;
         aux_modulus_out <= 1'b0;
         aux_sweep_out <= 1'b0;
         profile_sel_out <= 3'h0;
         latency_match_out <= 1'b1;
         lsb_first_out <= 1'b0;
         ftw_out <= 32'h0000_0000;
         pow_out <= 14'h0000;
      end else begin
         control_word_out <= cfr_active;
         aux_modulus_out <= aux_modulus;
         aux_sweep_out <= aux_sweep;
         profile_sel_out <= prof_sel;
         latency_match_out <= !cfr_active[dds_regs_pkg::CTRL_NO_MATCH_BIT]; // [RULE_11]
         lsb_first_out <= lsb_first;
         ftw_out <= prof_active[dds_regs_pkg::PROF_FTW_MSB:0]; // [RULE_14]
         pow_out <= prof_active[dds_regs_pkg::PROF_POW_MSB:dds_regs_pkg::PROF_POW_LSB]; // [RULE_14]
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_order_byte;
      wr_cfr && wr_idx == 3'(dds_regs_pkg::CTRL_LSB_FIRST_IDX) && !commit;
   endsequence

   chk_immediate_bit: assert property ( // [RULE_01]
      s_order_byte |=> (lsb_first == $past(rx_byte[7])) ##1 (lsb_first_out == $past(rx_byte[7], 2)))
      else $error("Order bit did not act on its byte write.");

   chk_addr_range: assert property ( // [RULE_02]
      (in_instr && !instr_ok) |=> state_r == dds_regs_pkg::ST_SKIP && !wr_cfr && !wr_prof)
      else $error("Out of range address was not skipped.");

   chk_unused_slot: assert property ( // [RULE_03]
      (in_data && addr_r == dds_regs_pkg::ADDR_UNUSED) |=> $stable(cfr_hold) && $stable(prof_hold))
      else $error("Unused slot changed a register.");

   chk_unused_read: assert property ( // [RULE_15]
      (ld && ld_addr == dds_regs_pkg::ADDR_UNUSED) |=> sdio_out == 1'b0)
      else $error("Unused slot read returned a one.");

   chk_byte_count: assert property ( // [RULE_04]
      (in_instr && instr_ok) |=> len_r == dds_regs_pkg::slot_bytes($past(instr_addr)) && cnt_r == 3'h0)
      else $error("Transfer length does not match the slot.");

   chk_commit_moves: assert property ( // [RULE_06]
      (commit && !wr_cfr && !wr_prof) |=> cfr_active == $past(cfr_hold) ##1 ftw_out == $past(prof_hold[31:0], 2))
      else $error("Commit did not move the buffers.");

   chk_waits_commit: assert property ( // [RULE_06]
      !commit |=> $stable(prof_active) && $stable(cfr_active & ~dds_regs_pkg::CTRL_IMMEDIATE))
      else $error("Staged bits moved without a commit.");

   chk_modulus_route: assert property ( // [RULE_09]
      1'b1 |=> aux_modulus_out == $past(aux_modulus) && !(aux_modulus_out && aux_sweep_out))
      else $error("Auxiliary accumulator routing is wrong.");

   chk_profile_src: assert property ( // [RULE_10]
      1'b1 |=> profile_sel_out == ($past(cfr_active[dds_regs_pkg::CTRL_INT_PROF_BIT]) ?
         $past(cfr_active[dds_regs_pkg::CTRL_PROF_SEL_MSB:dds_regs_pkg::CTRL_PROF_SEL_LSB]) : $past(prof_s2_r)))
      else $error("Profile source selection is wrong.");

   chk_latency_match: assert property ( // [RULE_11]
      1'b1 |=> latency_match_out == !$past(cfr_active[dds_regs_pkg::CTRL_NO_MATCH_BIT]))
      else $error("Latency match output is wrong.");

   chk_bit_order: assert property ( // [RULE_13]
      ld |=> sdio_out == ($past(lsb_first) ? $past(ld_byte[0]) : $past(ld_byte[7])))
      else $error("First read bit is in the wrong order.");

endmodule
`default_nettype wire

/* bench/host_serial_model.sv */
// Host controller model driving the serial programming port and the commit strobe.
// Assumes the bench calls its tasks one at a time and clk_in is the device clock.
`timescale 1ns/10ps
`default_nettype none
module host_serial_model (
   // Device clock and read data.
   input  wire logic clk_in,
   input  wire logic sdio_in,
   input  wire logic sdio_oe_in,
   // Pins driven towards the device.
   output logic      sclk_out,
   output logic      cs_n_out,
   output wire logic sdio_out,
   output logic      commit_out
);
   logic drv_r;

   // The data line is resolved here so the device sees its own read bits.
   assign sdio_out = sdio_oe_in ? sdio_in : drv_r;

   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      commit_out = 1'b0;
      drv_r = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   // Sclk half periods of 8 clocks leave the device room to present read data.
   task automatic bit_cycle(input logic b, output logic r);
      drv_r = b;
      wait_clk(8);
      r = sdio_in;
      sclk_out = 1'b1;
      wait_clk(8);
      sclk_out = 1'b0;
   endtask

   task automatic xfer(input logic rd, input logic [4:0] addr, input int nb, input logic [47:0] wd,
                       input logic lsb, output logic [47:0] rdat);
      logic [7:0] ins;
      logic       r;
      ins = {rd, 2'b00, addr};
      rdat = '0;
      cs_n_out = 1'b0;
      for (int i = 0; i < 8; i++) bit_cycle(lsb ? ins[i] : ins[7-i], r);
      for (int i = 0; i < 8 * nb; i++) begin
         bit_cycle(lsb ? wd[i] : wd[8*nb-1-i], r);
         if (lsb) rdat[i] = r;
         else rdat[8*nb-1-i] = r;
      end
      wait_clk(4);
      cs_n_out = 1'b1;
      drv_r = ~drv_r;
      wait_clk(8);
   endtask

   task automatic commit();
      commit_out = 1'b1;
      wait_clk(4);
      commit_out = 1'b0;
      wait_clk(8);
   endtask
endmodule
`default_nettype wire

/* bench/tb_dds_control_register_bank.sv */
// Self-checking bench for the synthesizer register bank.
// Assumes the host model owns the serial pins; the bench drives the rest at falling edges.
`timescale 1ns/10ps
`default_nettype none
module tb_dds_control_register_bank;
   logic        clk_in, rst_in, sclk, cs_n, io_update, sweep_en;
   wire logic   sdio;
   logic        sdo, sdo_oe, amod, aswp, lmatch, lsbf;
   logic [2:0]  pins, psel;
   logic [31:0] cw, ftw, prev;
   logic [13:0] pow;
   logic [47:0] rd, v, pv;
   int          err_count, num_checks, cycles;

   dds_control_register_bank dut_u (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
      .sdio_in(sdio), .sdio_out(sdo), .sdio_oe_out(sdo_oe), .io_update_in(io_update),
      .profile_pins_in(pins), .sweep_enable_in(sweep_en), .control_word_out(cw), .aux_modulus_out(amod),
      .aux_sweep_out(aswp), .profile_sel_out(psel), .latency_match_out(lmatch), .lsb_first_out(lsbf),
      .ftw_out(ftw), .pow_out(pow));
   host_serial_model host_u (.clk_in(clk_in), .sdio_in(sdo), .sdio_oe_in(sdo_oe), .sclk_out(sclk),
      .cs_n_out(cs_n), .sdio_out(sdio), .commit_out(io_update));

   function automatic logic [6:0] ctl_expect(input logic [31:0] c);
      return {c[28] & sweep_en, ~c[28] & sweep_en, c[27] ? c[22:20] : pins, ~c[26], c[23]};
   endfunction

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_ctl(input logic [31:0] c);
      chk({amod, aswp, psel, lmatch, lsbf}, ctl_expect(c));
      chk(cw, c);
   endtask

   task automatic final_report();
      $display("checks=%0d mismatches=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ****************************************
   // Clock and hang guard
   // ****************************************
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         final_report();
      end
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      rst_in = 1'b1;
      sweep_en = 1'b0;
      pins = 3'h0;
      prev = 32'h0;
      pv = 48'h0;
      void'($urandom(89677));
      repeat (16) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (8) @(negedge clk_in);
      check_ctl(32'h0);
      chk(ftw, 48'h0);
      chk(pow, 48'h0);
      // Host keeps the open bits and bit 23 clear so the bit order stays put.
      for (int k = 0; k < 6; k++) begin
         v = (k == 0) ? 48'h1C7F_FFFF : (k == 1) ? 48'h0 : {16'h0, $urandom} & 48'h1C7F_FFFF;
         sweep_en = 1'($urandom);
         pins = 3'($urandom);
         host_u.xfer(1'b0, 5'h00, 4, v, 1'b0, rd);
         check_ctl(prev);
         host_u.xfer(1'b1, 5'h00, 4, 48'h0, 1'b0, rd);
         chk(rd, v);
         host_u.commit();
         check_ctl(v[31:0]);
         prev = v[31:0];
      end
      for (int k = 0; k < 4; k++) begin
         v = (k == 0) ? 48'h3FFF_FFFF_FFFF : 48'({$urandom, $urandom}) & 48'h3FFF_FFFF_FFFF;
         host_u.xfer(1'b0, 5'h10, 6, v, 1'b0, rd);
         chk(ftw, pv[31:0]);
         host_u.xfer(1'b1, 5'h10, 6, 48'h0, 1'b0, rd);
         chk(rd, v);
         host_u.commit();
         chk(ftw, v[31:0]);
         chk(pow, v[45:32]);
         pv = v;
      end
      host_u.xfer(1'b0, 5'h05, 1, 48'hFF, 1'b0, rd);
      host_u.xfer(1'b1, 5'h05, 1, 48'h0, 1'b0, rd);
      chk(rd, 48'h0);
      host_u.xfer(1'b0, 5'h01, 4, 48'hFFFF_FFFF, 1'b0, rd);
      host_u.xfer(1'b1, 5'h01, 4, 48'h0, 1'b0, rd);
      chk(rd, 48'h0);
      host_u.xfer(1'b0, 5'h11, 4, 48'hFFFF_FFFF, 1'b0, rd);
      host_u.commit();
      check_ctl(prev);
      // Lower bytes are zero, so the order switch after byte two cannot garble them.
      host_u.xfer(1'b0, 5'h00, 4, 48'h0080_0000, 1'b0, rd);
      chk(lsbf, 48'h1);
      chk(cw, prev | 32'h0080_0000);
      host_u.xfer(1'b1, 5'h00, 4, 48'h0, 1'b1, rd);
      chk(rd, 48'h0080_0000);
      v = {16'h0, $urandom};
      host_u.xfer(1'b0, 5'h10, 6, v, 1'b1, rd);
      host_u.commit();
      chk(ftw, v[31:0]);
      check_ctl(32'h0080_0000);
      host_u.xfer(1'b0, 5'h00, 4, 48'h0, 1'b1, rd);
      chk(lsbf, 48'h0);
      final_report();
   end
endmodule
`default_nettype wire
